//--- design/fcrl_top.sv
// Flash configuration reset loader with backdoor key and trim load
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
`include "fcrl_consts.svh"

module fcrl_top (
	input  wire logic                        REF_CLK,
	input  wire logic                        RST,
	input  wire logic                        DEBUG_ACTIVE,
	input  wire logic                        PROD_TEST,
	input  wire logic [7:0]                  REG_ADDR,
	input  wire logic [31:0]                 REG_WDATA,
	input  wire logic                        REG_WR,
	input  wire logic                        REG_RD,
	input  wire logic                        REG_DEBUG,
	input  wire logic [7:0]                  FLASH_RDATA,
	input  wire logic                        MASS_ERASE_DONE,
	input  wire logic                        BLANK_CHECK_OK,
	output fcrl_pkg::fcrl_flash_req_type     FLASH_REQ,
	output logic [31:0]                      REG_RDATA,
	output fcrl_pkg::fcrl_protect_type       PROTECT,
	output fcrl_pkg::fcrl_option_type        OPTION,
	output logic [7:0]                       COARSE_TRIM,
	output logic                             FINE_TRIM,
	output logic                             MEM_SECURE,
	output logic                             LOAD_DONE
);
	import fcrl_pkg::*;

	fcrl_state_type     state, next_state;
	logic [3:0]         step, next_step;
	logic [1:0]         sync_cnt, next_sync_cnt;
	logic               debug_at_reset, next_debug_at_reset;
	fcrl_flash_req_type req, next_req;
	fcrl_protect_type   prot, next_prot;
	fcrl_option_type    opt, next_opt;
	logic [7:0]         coarse, next_coarse;
	logic               fine, next_fine;
	logic [7:0]         info_coarse, next_info_coarse;
	logic               info_fine, next_info_fine;
	logic [7:0]         key_bytes [8];
	logic [7:0]         next_key_bytes [8];
	logic [63:0]        key_flat;
	logic               load_done, next_load_done;
	logic [31:0]        key_first, next_key_first;
	logic [31:0]        key_second, next_key_second;
	logic               key_unlocked, next_key_unlocked;
	logic               key_rejected, next_key_rejected;
	logic               erase_seen, next_erase_seen;
	logic               erase_unlocked, next_erase_unlocked;
	logic               secure, next_secure;
	logic [31:0]        rdata, next_rdata;
	logic [1:0]         pins_sync;
	logic               debug_sync;
	logic               test_sync;
	logic               key_en;
	logic               key_cmd;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	fcrl_sync #(
		.WIDTH (2)
	) u_sync (
		.REF_CLK  (REF_CLK),
		.RST      (RST),
		.ASYNC_IN ({PROD_TEST, DEBUG_ACTIVE}),
		.SYNC_OUT (pins_sync)
	);
	assign debug_sync = pins_sync[0];
	assign test_sync  = pins_sync[1];

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_key
			assign key_flat[63-8*gi -: 8] = key_bytes[gi];
		end
	endgenerate

	assign key_en  = (opt.key_enable == `FCRL_KEY_ENABLE_CODE);
	assign key_cmd = REG_WR && (REG_ADDR == `FCRL_REG_KEY_CONTROL) && REG_WDATA[0];

	////////////////////////////////////////////////////////////////////////////
	// Reset loader and trim registers
	always_comb
	begin
		next_state          = state;
		next_step           = step;
		next_sync_cnt       = sync_cnt;
		next_debug_at_reset = debug_at_reset;
		next_req            = req;
		next_prot           = prot;
		next_opt            = opt;
		next_coarse         = coarse;
		next_fine           = fine;
		next_info_coarse    = info_coarse;
		next_info_fine      = info_fine;
		next_key_bytes      = key_bytes;
		next_load_done      = load_done;
		case (state)
			ST_SYNC:
			begin
				if (sync_cnt == `FCRL_SYNC_CYCLES)
				begin
					next_debug_at_reset = debug_sync;
					next_step = debug_sync ? `FCRL_STEP_PROT : `FCRL_STEP_INFO_FINE;
					next_state = ST_ISSUE;
				end
				else
				begin
					next_sync_cnt = sync_cnt + 2'h1;
				end
			end
			ST_ISSUE:
			begin
				next_req.rd   = 1'b1;
				next_req.info = (step < `FCRL_STEP_PROT);
				if (step == `FCRL_STEP_INFO_FINE)
					next_req.addr = `FCRL_ADDR_INFO_FINE;
				else if (step == `FCRL_STEP_INFO_COARSE)
					next_req.addr = `FCRL_ADDR_INFO_COARSE;
				else if (step == `FCRL_STEP_PROT)
					next_req.addr = `FCRL_ADDR_PROT_STORE;
				else if (step == `FCRL_STEP_OPT)
					next_req.addr = `FCRL_ADDR_OPT_STORE;
				else
					next_req.addr = `FCRL_ADDR_KEY_BASE + 17'(step - `FCRL_STEP_KEY);
				next_state = ST_WAIT;
			end
			ST_WAIT:
			begin
				next_req   = '0;
				next_state = ST_CAPTURE;
			end
			ST_CAPTURE:
			begin
				if (step == `FCRL_STEP_INFO_FINE)
				begin
					next_fine      = FLASH_RDATA[0];
					next_info_fine = FLASH_RDATA[0];
				end
				else if (step == `FCRL_STEP_INFO_COARSE)
				begin
					next_coarse      = FLASH_RDATA;
					next_info_coarse = FLASH_RDATA;
				end
				else if (step == `FCRL_STEP_PROT)
					next_prot = FLASH_RDATA;
				else if (step == `FCRL_STEP_OPT)
					next_opt = {FLASH_RDATA[7:6], 4'h0, FLASH_RDATA[1:0]};
				else
					next_key_bytes[3'(step - `FCRL_STEP_KEY)] = FLASH_RDATA;
				if (step == `FCRL_STEP_LAST)
				begin
					next_load_done = 1'b1;
					next_state     = ST_DONE;
				end
				else
				begin
					next_step  = step + 4'h1;
					next_state = ST_ISSUE;
				end
			end
			default:
			begin
				next_state = ST_DONE;
			end
		endcase
		if (REG_WR && (REG_ADDR == `FCRL_REG_COARSE_TRIM))
			next_coarse = REG_WDATA[7:0];
		else if (REG_WR && (REG_ADDR == `FCRL_REG_CLOCK_STATUS))
			next_fine = REG_WDATA[0];
	end

	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			state          <= ST_SYNC;
			step           <= 4'h0;
			sync_cnt       <= 2'h0;
			debug_at_reset <= 1'b0;
			req            <= '0;
			prot           <= '0;
			opt            <= '0;
			coarse         <= `FCRL_COARSE_TRIM_RST;
			fine           <= `FCRL_FINE_TRIM_RST;
			info_coarse    <= 8'h00;
			info_fine      <= 1'b0;
			key_bytes      <= '{default: 8'h00};
			load_done      <= 1'b0;
		end
		else
		begin
			state          <= next_state;
			step           <= next_step;
			sync_cnt       <= next_sync_cnt;
			debug_at_reset <= next_debug_at_reset;
			req            <= next_req;
			prot           <= next_prot;
			opt            <= next_opt;
			coarse         <= next_coarse;
			fine           <= next_fine;
			info_coarse    <= next_info_coarse;
			info_fine      <= next_info_fine;
			key_bytes      <= next_key_bytes;
			load_done      <= next_load_done;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Security, key entry and register reads
	always_comb
	begin
		next_key_first      = key_first;
		next_key_second     = key_second;
		next_key_unlocked   = key_unlocked;
		next_key_rejected   = key_rejected;
		next_erase_seen     = erase_seen;
		next_erase_unlocked = erase_unlocked;
		next_rdata          = 32'h0000_0000;
		if (REG_WR && !REG_DEBUG && (REG_ADDR == `FCRL_REG_KEY_FIRST))
			next_key_first = REG_WDATA;
		else if (REG_WR && !REG_DEBUG && (REG_ADDR == `FCRL_REG_KEY_SECOND))
			next_key_second = REG_WDATA;
		if (key_cmd && REG_DEBUG)
			next_key_rejected = 1'b1;
		else if (key_cmd && key_en && load_done && ({key_first, key_second} == key_flat))
			next_key_unlocked = 1'b1;
		if (MASS_ERASE_DONE)
			next_erase_seen = 1'b1;
		if (BLANK_CHECK_OK && erase_seen)
			next_erase_unlocked = 1'b1;
		if (REG_RD)
		begin
			if (REG_ADDR == `FCRL_REG_PROTECT)
				next_rdata = {24'h00_0000, prot};
			else if (REG_ADDR == `FCRL_REG_OPTION)
				next_rdata = {24'h00_0000, opt};
			else if (REG_ADDR == `FCRL_REG_COARSE_TRIM)
				next_rdata = {24'h00_0000, coarse};
			else if (REG_ADDR == `FCRL_REG_CLOCK_STATUS)
				next_rdata = {31'h0000_0000, fine};
			else if (REG_ADDR == `FCRL_REG_STATUS)
				next_rdata = {27'h000_0000, key_rejected, erase_unlocked, key_unlocked,
					secure, load_done};
			else if ((REG_ADDR == `FCRL_REG_INFO_TRIM) && test_sync)
				next_rdata = {16'h0000, info_coarse, 7'h00, info_fine};
		end
	end

	assign next_secure = !load_done || ((opt.security != `FCRL_UNSECURE_CODE)
		&& !key_unlocked && !erase_unlocked);

	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			key_first      <= 32'h0000_0000;
			key_second     <= 32'h0000_0000;
			key_unlocked   <= 1'b0;
			key_rejected   <= 1'b0;
			erase_seen     <= 1'b0;
			erase_unlocked <= 1'b0;
			secure         <= 1'b1;
			rdata          <= 32'h0000_0000;
		end
		else
		begin
			key_first      <= next_key_first;
			key_second     <= next_key_second;
			key_unlocked   <= next_key_unlocked;
			key_rejected   <= next_key_rejected;
			erase_seen     <= next_erase_seen;
			erase_unlocked <= next_erase_unlocked;
			secure         <= next_secure;
			rdata          <= next_rdata;
		end
	end

	assign FLASH_REQ   = req;
	assign REG_RDATA   = rdata;
	assign PROTECT     = prot;
	assign OPTION      = opt;
	assign COARSE_TRIM = coarse;
	assign FINE_TRIM   = fine;
	assign MEM_SECURE  = secure;
	assign LOAD_DONE   = load_done;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_opt_load;
		@(posedge REF_CLK) disable iff (RST)
		(state == ST_CAPTURE) && (step == `FCRL_STEP_OPT) |=>
			(OPTION == {$past(FLASH_RDATA[7:6]), 4'h0, $past(FLASH_RDATA[1:0])});
	endproperty
	a_opt_load: assert property (p_opt_load) else $error("option byte load wrong");

	property p_prot_load;
		@(posedge REF_CLK) disable iff (RST)
		(state == ST_CAPTURE) && (step == `FCRL_STEP_PROT) |=> (PROTECT == $past(FLASH_RDATA));
	endproperty
	a_prot_load: assert property (p_prot_load) else $error("protect byte load wrong");

	property p_key_addr;
		@(posedge REF_CLK) disable iff (RST)
		(state == ST_ISSUE) && (step >= `FCRL_STEP_KEY) |=> FLASH_REQ.rd && !FLASH_REQ.info
			&& (FLASH_REQ.addr == `FCRL_ADDR_KEY_BASE + 17'($past(step) - `FCRL_STEP_KEY));
	endproperty
	a_key_addr: assert property (p_key_addr) else $error("key byte address wrong");

	property p_trim_load;
		@(posedge REF_CLK) disable iff (RST)
		(state == ST_CAPTURE) && (step == `FCRL_STEP_INFO_COARSE) && !REG_WR
			|=> (COARSE_TRIM == $past(FLASH_RDATA));
	endproperty
	a_trim_load: assert property (p_trim_load) else $error("coarse trim not loaded");

	property p_debug_skip;
		@(posedge REF_CLK) disable iff (RST)
		debug_at_reset && (state == ST_ISSUE) |-> ##1 !FLASH_REQ.info ##1 (state == ST_CAPTURE);
	endproperty
	a_debug_skip: assert property (p_debug_skip) else $error("info row read in debug");

	property p_key_unlock;
		@(posedge REF_CLK) disable iff (RST)
		key_cmd && !REG_DEBUG && key_en && load_done && ({key_first, key_second} == key_flat)
			|=> key_unlocked ##1 !MEM_SECURE;
	endproperty
	a_key_unlock: assert property (p_key_unlock) else $error("matching key ignored");

	property p_debug_reject;
		@(posedge REF_CLK) disable iff (RST)
		REG_WR && REG_DEBUG |=> $stable(key_unlocked) && $stable(key_first)
			&& $stable(key_second);
	endproperty
	a_debug_reject: assert property (p_debug_reject) else $error("debug key taken");

	property p_key_disabled;
		@(posedge REF_CLK) disable iff (RST)
		!key_en && !key_unlocked |=> !key_unlocked;
	endproperty
	a_key_disabled: assert property (p_key_disabled) else $error("disabled key unlocked");

	property p_erase;
		@(posedge REF_CLK) disable iff (RST)
		$rose(erase_unlocked) |-> $past(erase_seen) && $past(BLANK_CHECK_OK);
	endproperty
	a_erase: assert property (p_erase) else $error("erase unlock without blank");

	property p_info_gate;
		@(posedge REF_CLK) disable iff (RST)
		REG_RD && (REG_ADDR == `FCRL_REG_INFO_TRIM) && !test_sync |=> (REG_RDATA == 32'h0000_0000)
			and (FLASH_REQ.info |-> !LOAD_DONE);
	endproperty
	a_info_gate: assert property (p_info_gate) else $error("info row exposed");

endmodule : fcrl_top

//--- common/fcrl_consts.svh
// Offsets, field codes, reset values and counts of the config loader
`ifndef FCRL_CONSTS_SVH
`define FCRL_CONSTS_SVH

// Flash byte addresses of the reserved configuration field
`define FCRL_ADDR_FINE_STORE    17'h0_03fe
`define FCRL_ADDR_COARSE_STORE  17'h0_03ff
`define FCRL_ADDR_KEY_BASE      17'h0_0400
`define FCRL_ADDR_KEY_SECOND    17'h0_0404
`define FCRL_ADDR_PROT_STORE    17'h0_040d
`define FCRL_ADDR_OPT_STORE     17'h0_040f
// Hidden information row addresses of factory trim
`define FCRL_ADDR_INFO_FINE     17'h0_0000
`define FCRL_ADDR_INFO_COARSE   17'h0_0001

// Register port offsets
`define FCRL_REG_PROTECT        8'h00
`define FCRL_REG_OPTION         8'h04
`define FCRL_REG_COARSE_TRIM    8'h08
`define FCRL_REG_CLOCK_STATUS   8'h0c
`define FCRL_REG_KEY_FIRST      8'h10
`define FCRL_REG_KEY_SECOND     8'h14
`define FCRL_REG_KEY_CONTROL    8'h18
`define FCRL_REG_STATUS         8'h1c
`define FCRL_REG_INFO_TRIM      8'h20

// Field codes and reset values
`define FCRL_KEY_ENABLE_CODE    2'h2
`define FCRL_UNSECURE_CODE      2'h2
`define FCRL_COARSE_TRIM_RST    8'h80
`define FCRL_FINE_TRIM_RST      1'h0

// Load sequence steps and counts
`define FCRL_STEP_INFO_FINE     4'h0
`define FCRL_STEP_INFO_COARSE   4'h1
`define FCRL_STEP_PROT          4'h2
`define FCRL_STEP_OPT           4'h3
`define FCRL_STEP_KEY           4'h4
`define FCRL_STEP_LAST          4'hb
`define FCRL_SYNC_CYCLES        2'h2

`endif

//--- common/fcrl_pkg.sv
// Types of the flash config reset loader
package fcrl_pkg;

	typedef enum logic [4:0] {
		ST_SYNC    = 5'h01,
		ST_ISSUE   = 5'h02,
		ST_WAIT    = 5'h04,
		ST_CAPTURE = 5'h08,
		ST_DONE    = 5'h10
	} fcrl_state_type;

	typedef struct packed {
		logic        rd;
		logic        info;
		logic [16:0] addr;
	} fcrl_flash_req_type;

	typedef struct packed {
		logic [6:0] size;
		logic       open;
	} fcrl_protect_type;

	typedef struct packed {
		logic [1:0] key_enable;
		logic [3:0] zero;
		logic [1:0] security;
	} fcrl_option_type;

endpackage : fcrl_pkg

//--- design/fcrl_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns

module fcrl_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             REF_CLK,
	input  wire logic             RST,
	input  wire logic [WIDTH-1:0] ASYNC_IN,
	output logic      [WIDTH-1:0] SYNC_OUT
);

	logic [WIDTH-1:0] stage1;

	////////////////////////////////////////////////////////////////////////////
	// One pair of flops per bit
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge REF_CLK or posedge RST)
			begin
				if (RST)
				begin
					stage1[i]   <= 1'b0;
					SYNC_OUT[i] <= 1'b0;
				end
				else
				begin
					stage1[i]   <= ASYNC_IN[i];
					SYNC_OUT[i] <= stage1[i];
				end
			end
		end
	endgenerate

endmodule : fcrl_sync

//--- tb/fcrl_flash_model.sv
// Behavioural flash array answering the loader's byte reads
`timescale 1ns/1ns
`include "fcrl_consts.svh"

module fcrl_flash_model (
	input  wire logic                     REF_CLK,
	input  fcrl_pkg::fcrl_flash_req_type  FLASH_REQ,
	input  wire logic [63:0]              KEY_BYTES,
	input  wire logic [7:0]               PROT_BYTE,
	input  wire logic [7:0]               OPT_BYTE,
	input  wire logic [7:0]               INFO_COARSE,
	input  wire logic                     INFO_FINE,
	input  wire logic [7:0]               USER_COARSE,
	input  wire logic                     USER_FINE,
	output logic [7:0]                    FLASH_RDATA
);
	import fcrl_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Byte held at a requested location
	function automatic logic [7:0] stored_byte(input fcrl_flash_req_type req);
		int idx;
		idx = 7 - int'(req.addr[2:0]);
		if (req.info)
			return (req.addr == `FCRL_ADDR_INFO_FINE) ? {7'h00, INFO_FINE} : INFO_COARSE;
		if ((req.addr & 17'h1_fff8) == `FCRL_ADDR_KEY_BASE)
			return KEY_BYTES[idx*8 +: 8];
		case (req.addr)
			`FCRL_ADDR_FINE_STORE:   return {7'h00, USER_FINE};
			`FCRL_ADDR_COARSE_STORE: return USER_COARSE;
			`FCRL_ADDR_PROT_STORE:   return PROT_BYTE;
			`FCRL_ADDR_OPT_STORE:    return OPT_BYTE;
			default:                 return 8'hff;
		endcase
	endfunction : stored_byte

	////////////////////////////////////////////////////////////////////////
	// Answer one cycle after a read; idle line inverts the byte it shows on every cycle
	initial FLASH_RDATA = 8'h00;

	always @(posedge REF_CLK)
	begin
		if (FLASH_REQ.rd)
			FLASH_RDATA <= stored_byte(FLASH_REQ);
		else
			FLASH_RDATA <= ~FLASH_RDATA;
	end

endmodule : fcrl_flash_model

//--- tb/fcrl_tb.sv
// Self-checking bench of the flash config reset loader
`timescale 1ns/1ns
`include "fcrl_consts.svh"

module fcrl_tb;
	import fcrl_pkg::*;

	logic               ref_clk = 1'b0;
	logic               rst = 1'b1;
	logic               debug_active = 1'b0;
	logic               prod_test = 1'b0;
	logic [7:0]         reg_addr = 8'h00;
	logic [31:0]        reg_wdata = 32'h0000_0000;
	logic               reg_wr = 1'b0;
	logic               reg_rd = 1'b0;
	logic               reg_debug = 1'b0;
	logic               mass_erase_done = 1'b0;
	logic               blank_check_ok = 1'b0;
	logic [63:0]        key = 64'h0;
	logic [7:0]         prot = 8'h00;
	logic [7:0]         opt = 8'h00;
	logic [7:0]         info_coarse = 8'h00;
	logic               info_fine = 1'b0;
	logic [7:0]         user_coarse = 8'h00;
	logic               user_fine = 1'b0;
	logic [7:0]         flash_rdata;
	logic [31:0]        reg_rdata;
	fcrl_flash_req_type flash_req;
	fcrl_protect_type   protect;
	fcrl_option_type    option;
	logic [7:0]         coarse_trim;
	logic               fine_trim;
	logic               mem_secure;
	logic               load_done;
	int                 fails = 0;
	int                 checked = 0;
	int unsigned        junk;

	fcrl_top fcrl_top_inst (.REF_CLK(ref_clk), .RST(rst), .DEBUG_ACTIVE(debug_active),
		.PROD_TEST(prod_test), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_DEBUG(reg_debug), .FLASH_RDATA(flash_rdata),
		.MASS_ERASE_DONE(mass_erase_done), .BLANK_CHECK_OK(blank_check_ok),
		.FLASH_REQ(flash_req), .REG_RDATA(reg_rdata), .PROTECT(protect), .OPTION(option),
		.COARSE_TRIM(coarse_trim), .FINE_TRIM(fine_trim), .MEM_SECURE(mem_secure),
		.LOAD_DONE(load_done));

	fcrl_flash_model fcrl_flash_model_inst (.REF_CLK(ref_clk), .FLASH_REQ(flash_req),
		.KEY_BYTES(key), .PROT_BYTE(prot), .OPT_BYTE(opt), .INFO_COARSE(info_coarse),
		.INFO_FINE(info_fine), .USER_COARSE(user_coarse), .USER_FINE(user_fine),
		.FLASH_RDATA(flash_rdata));

	////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial
	begin
		forever #4 ref_clk = ~ref_clk;
	end

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		$display("[FAIL] %0t watchdog expired", $time);
		tally_and_finish();
	end

	////////////////////////////////////////////////////////////////////////
	// Expected values
	function automatic logic [7:0] exp_option(input logic [7:0] o);
		return {o[7:6], 4'h0, o[1:0]};
	endfunction : exp_option

	function automatic logic [8:0] exp_trim(input logic dbg);
		return dbg ? {`FCRL_FINE_TRIM_RST, `FCRL_COARSE_TRIM_RST} : {info_fine, info_coarse};
	endfunction : exp_trim

	function automatic logic exp_secure(input logic [7:0] o, input logic keyed);
		return (o[1:0] != `FCRL_UNSECURE_CODE) && !(keyed && o[7:6] == `FCRL_KEY_ENABLE_CODE);
	endfunction : exp_secure

	////////////////////////////////////////////////////////////////////////
	// Compares and bus tasks
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask : check_val

	task automatic check_flag(input logic got, input logic exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : check_flag

	task automatic reg_write(input logic [7:0] addr, input logic [31:0] data, input logic dbg);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= addr;
		reg_wdata <= data;
		reg_debug <= dbg;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_debug <= 1'b0;
	endtask : reg_write

	task automatic read_check(input logic [7:0] addr, input logic [31:0] mask,
		input logic [31:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= addr;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		check_val(reg_rdata & mask, exp);
	endtask : read_check

	task automatic key_try(input logic [63:0] k, input logic dbg);
		reg_write(`FCRL_REG_KEY_FIRST, k[63:32], dbg);
		reg_write(`FCRL_REG_KEY_SECOND, k[31:0], dbg);
		reg_write(`FCRL_REG_KEY_CONTROL, 32'h0000_0001, dbg);
		repeat (3) @(posedge ref_clk);
		#1;
	endtask : key_try

	task automatic pulse(input logic erase, input logic blank);
		@(posedge ref_clk);
		mass_erase_done <= erase;
		blank_check_ok <= blank;
		@(posedge ref_clk);
		mass_erase_done <= 1'b0;
		blank_check_ok <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask : pulse

	task automatic run_reset(input logic dbg, input logic [1:0] ken, input logic [1:0] sec);
		int n;
		@(posedge ref_clk);
		rst <= 1'b1;
		debug_active <= dbg;
		key <= {$urandom, $urandom};
		prot <= 8'($urandom);
		opt <= {ken, 4'($urandom), sec};
		info_coarse <= 8'($urandom);
		info_fine <= 1'($urandom);
		user_coarse <= 8'($urandom);
		user_fine <= 1'($urandom);
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		n = 0;
		while (load_done !== 1'b1 && n < 200)
		begin
			@(posedge ref_clk);
			n++;
		end
		repeat (2) @(posedge ref_clk);
		#1;
		check_flag(load_done, 1'b1);
		check_val(32'({protect, option}), 32'({prot, exp_option(opt)}));
		check_val(32'({fine_trim, coarse_trim}), 32'(exp_trim(dbg)));
		check_flag(mem_secure, exp_secure(opt, 1'b0));
	endtask : run_reset

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////////
	// Test sequence
	initial
	begin
		junk = $urandom(91);
		run_reset(1'b0, `FCRL_KEY_ENABLE_CODE, 2'b00);
		read_check(`FCRL_REG_PROTECT, 32'h0000_00ff, {24'h0, prot});
		read_check(`FCRL_REG_OPTION, 32'hffff_ffff, {24'h0, exp_option(opt)});
		read_check(8'h3c, 32'hffff_ffff, 32'h0000_0000);
		read_check(`FCRL_REG_INFO_TRIM, 32'hffff_ffff, 32'h0000_0000);
		@(posedge ref_clk);
		prod_test <= 1'b1;
		repeat (4) @(posedge ref_clk);
		read_check(`FCRL_REG_INFO_TRIM, 32'h0000_ff01,
			{16'h0, info_coarse, 7'h0, info_fine});
		@(posedge ref_clk);
		prod_test <= 1'b0;
		reg_write(`FCRL_REG_COARSE_TRIM, {24'h0, user_coarse}, 1'b0);
		reg_write(`FCRL_REG_CLOCK_STATUS, {31'h0, user_fine}, 1'b0);
		#1;
		check_val(32'({fine_trim, coarse_trim}), 32'({user_fine, user_coarse}));
		$display("test load and trim done");
		key_try(key, 1'b1);
		check_flag(mem_secure, 1'b1);
		read_check(`FCRL_REG_STATUS, 32'h0000_001c, 32'h0000_0010);
		key_try(key ^ 64'h1, 1'b0);
		check_flag(mem_secure, 1'b1);
		key_try(key, 1'b0);
		check_flag(mem_secure, 1'b0);
		read_check(`FCRL_REG_STATUS, 32'h0000_001c, 32'h0000_0014);
		$display("test backdoor key done");
		run_reset(1'b1, 2'b01, 2'b11);
		key_try(key, 1'b0);
		check_flag(mem_secure, 1'b1);
		pulse(1'b0, 1'b1);
		check_flag(mem_secure, 1'b1);
		pulse(1'b1, 1'b0);
		check_flag(mem_secure, 1'b1);
		pulse(1'b0, 1'b1);
		check_flag(mem_secure, 1'b0);
		$display("test key disabled and erase done");
		repeat (8)
		begin
			run_reset(1'($urandom), 2'($urandom), 2'($urandom));
			key_try(key, 1'b0);
			check_flag(mem_secure, exp_secure(opt, 1'b1));
		end
		$display("test random resets done");
		tally_and_finish();
	end

endmodule : fcrl_tb
